// File: rhce_consts.svh
// Behaviour
// - Parallel branch bits follow the high serial bit by half a bit clock period.
// - Every accepted input bit yields exactly two serial output bits.
// - Each codeword goes out high branch bit first, then low branch bit.
// - Systematic code carries the input bit unchanged as its high branch.
// - Nonsystematic code uses current input plus two earlier inputs.
// - Systematic code output depends on current input plus three earlier terms.
// - Test mode feeds a constant one into the encoder instead of input data.
// - Bit clock output is synchronous and in phase with serial output.
// - Nonsystematic low bit uses D^2+1, high bit uses D^2+D+1.
// - Systematic parity check D^3+D+1 on low branch, D^2 on high.
// - Bit clock is master divided by four, sampling clock by eight.
// - Reset clears encoder memory and restarts dividers at a known phase.
`ifndef RHCE_CONSTS_SVH
`define RHCE_CONSTS_SVH
`define RHCE_PH_W      3
`define RHCE_PH_WORD   3'h0
`define RHCE_PH_PAR    3'h2
`define RHCE_PH_LOW    3'h4
`define RHCE_PH_RST    3'h7
`define RHCE_FIFO_W    1
`define RHCE_FIFO_D    16
`endif

// File: rhce_encoder.sv
`timescale 1ns/1ps
`include "rhce_consts.svh"
module rhce_fifo #(
  parameter int W  = `RHCE_FIFO_W,
  parameter int D  = `RHCE_FIFO_D,
  localparam int AW = $clog2(D)
) (
  // Clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         rst_i,
  // Fill side
  input  wire logic [W-1:0] in_data_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  // Drain side
  output logic [W-1:0]      out_data_o,
  output logic              out_valid_o,
  input  wire logic         out_ready_i
);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
    logic          in_rdy;
    logic          out_vld;
  } rhce_fifo_state_s;

  rhce_fifo_state_s r_reg;
  rhce_fifo_state_s r_next;
  logic [W-1:0]     mem [D];
  logic             push;
  logic             pop;

  always_comb begin
    r_next = r_reg;
    push = in_valid_i && r_reg.in_rdy;
    pop = out_ready_i && r_reg.out_vld;
    if (push) begin
      r_next.wp = r_reg.wp + AW'(1);
    end
    if (pop) begin
      r_next.rp = r_reg.rp + AW'(1);
    end
    r_next.cnt = r_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    r_next.in_rdy = r_next.cnt != (AW+1)'(D);
    r_next.out_vld = r_next.cnt != '0;
    if (rst_i) begin
      r_next = '0;
      r_next.in_rdy = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    r_reg <= r_next;
    if (push) begin
      mem[r_reg.wp] <= in_data_i;
    end
  end

  assign in_ready_o  = r_reg.in_rdy;
  assign out_valid_o = r_reg.out_vld;
  assign out_data_o  = mem[r_reg.rp];

  a_fifo_full_stop: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (r_reg.cnt == (AW+1)'(D)) |-> !in_ready_o)
    else $error("fifo ready while full");

  a_fifo_empty_flag: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (r_reg.cnt == '0) |-> !out_valid_o)
    else $error("fifo valid while empty");

  a_fifo_count_up: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (push && !pop) |=> r_reg.cnt == $past(r_reg.cnt) + (AW+1)'(1))
    else $error("fifo count did not follow a push");
endmodule : rhce_fifo

module rhce_encoder
  import rhce_pkg::*;
(
  // Master clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  // Selections
  input  wire rhce_code_e code_sel_i,
  input  wire rhce_mode_e mode_sel_i,
  // Input data stream
  input  wire logic       data_i,
  input  wire logic       data_valid_i,
  output logic            data_ready_o,
  // Serial outputs
  output logic            serial_data_o,
  output logic            bipolar_serial_out_o,
  output logic            bit_clk_o,
  // Parallel outputs
  output rhce_word_s      par_word_o,
  output logic [1:0]      four_level_out_o,
  // Sampling clock and status
  output logic            sample_clk_o,
  output logic            underrun_o
);
  rhce_state_s r_reg;
  rhce_state_s r_next;
  logic        fifo_data;
  logic        fifo_valid;
  logic        fifo_pop;
  logic        u_in;

  function automatic rhce_word_s rhce_encode(input rhce_code_e code,
                                             input logic [2:0] uh,
                                             input logic [2:0] ph);
    rhce_word_s w;
    if (code == rhce_code_sys) begin
      w.hi = uh[0];
      w.lo = ph[0] ^ ph[2] ^ uh[2];
    end else begin
      w.hi = uh[0] ^ uh[1] ^ uh[2];
      w.lo = uh[0] ^ uh[2];
    end
    return w;
  endfunction : rhce_encode

  rhce_fifo #(
    .W (`RHCE_FIFO_W),
    .D (`RHCE_FIFO_D)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .rst_i       (rst_i),
    .in_data_i   (data_i),
    .in_valid_i  (data_valid_i),
    .in_ready_o  (data_ready_o),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop)
  );

  always_comb begin
    r_next = r_reg;
    fifo_pop = 1'b0;
    u_in = 1'b0;
    r_next.phase = r_reg.phase + 3'h1;
    r_next.bclk = ~r_next.phase[1];
    r_next.sclk = ~r_next.phase[2];
    if (r_next.phase == `RHCE_PH_WORD) begin
      r_next.code = code_sel_i;
      r_next.mode = mode_sel_i;
      if (mode_sel_i == rhce_mode_test) begin
        u_in = 1'b1;
        r_next.underrun = 1'b0;
      end else begin
        fifo_pop = fifo_valid;
        u_in = fifo_valid & fifo_data;
        r_next.underrun = !fifo_valid;
      end
      r_next.u_hist = {r_reg.u_hist[1:0], u_in};
      r_next.word = rhce_encode(code_sel_i, r_next.u_hist, r_reg.par_hist);
      r_next.par_hist = {r_reg.par_hist[1:0], r_next.word.lo};
      r_next.ser = r_next.word.hi;
    end else if (r_next.phase == `RHCE_PH_LOW) begin
      r_next.ser = r_reg.word.lo;
    end else if (r_next.phase == `RHCE_PH_PAR) begin
      r_next.par = r_reg.word;
    end
    if (rst_i) begin
      r_next = '0;
      r_next.phase = `RHCE_PH_RST;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    r_reg <= r_next;
  end

  // clock and data from same flops
  assign serial_data_o        = r_reg.ser;
  assign bipolar_serial_out_o = r_reg.ser;
  assign bit_clk_o            = r_reg.bclk;
  assign sample_clk_o         = r_reg.sclk;
  assign par_word_o           = r_reg.par;
  assign four_level_out_o     = {r_reg.par.hi, r_reg.par.lo};
  assign underrun_o           = r_reg.underrun;

  // Words since reset, for history checks
  logic [1:0] seen_reg;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      seen_reg <= 2'h0;
    end else if (r_reg.phase == `RHCE_PH_WORD && seen_reg != 2'h3) begin
      seen_reg <= seen_reg + 2'h1;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  a_bclk_div_four: assert property (
    $rose(bit_clk_o) |=> bit_clk_o ##1 !bit_clk_o [*2] ##1 bit_clk_o)
    else $error("bit clock not master divided by four");

  a_sclk_div_eight: assert property (
    $rose(sample_clk_o) |=> sample_clk_o [*3] ##1 !sample_clk_o [*4] ##1 sample_clk_o)
    else $error("sampling clock not master divided by eight");

  a_par_half_delay: assert property (
    $rose(sample_clk_o) |-> ##2 (par_word_o.hi == $past(serial_data_o, 2)))
    else $error("parallel high bit not half bit clock behind serial");

  a_low_second: assert property (
    $rose(sample_clk_o) |-> ##4 (serial_data_o == par_word_o.lo && $rose(bit_clk_o)))
    else $error("low branch bit not sent second");

  a_serial_on_bclk: assert property (
    $changed(serial_data_o) |-> $rose(bit_clk_o))
    else $error("serial data changed off the bit clock edge");

  a_two_bits_word: assert property (
    $changed(serial_data_o) |->
      (r_reg.phase == `RHCE_PH_WORD || r_reg.phase == `RHCE_PH_LOW))
    else $error("serial output changed outside its two bit slots");

  a_test_ones: assert property (
    (r_reg.phase == `RHCE_PH_WORD && r_reg.mode == rhce_mode_test) |->
      r_reg.u_hist[0] && !fifo_pop)
    else $error("test mode did not feed a one");

  a_sys_copy: assert property (
    (r_reg.phase == `RHCE_PH_WORD && r_reg.code == rhce_code_sys) |->
      serial_data_o == r_reg.u_hist[0])
    else $error("systematic code lost the input bit");

  a_nonsys_low: assert property (
    (r_reg.phase == `RHCE_PH_WORD && r_reg.code == rhce_code_nonsys && seen_reg == 2'h3) |->
      r_reg.word.lo == (r_reg.u_hist[0] ^ $past(r_reg.u_hist[0], 16)))
    else $error("nonsystematic low branch wrong");

  a_sys_parity: assert property (
    (r_reg.phase == `RHCE_PH_WORD && r_reg.code == rhce_code_sys && seen_reg == 2'h3) |->
      r_reg.word.lo == ($past(r_reg.word.lo, 8) ^ $past(r_reg.word.lo, 24)
                        ^ $past(r_reg.u_hist[0], 16)))
    else $error("systematic parity branch wrong");

  a_sel_boundary: assert property (
    (r_reg.phase != `RHCE_PH_WORD) |-> $stable(r_reg.code) && $stable(r_reg.mode))
    else $error("code or mode changed inside a codeword");

  a_pop_sample: assert property (
    fifo_pop |=> r_reg.phase == `RHCE_PH_WORD ##8 r_reg.phase == `RHCE_PH_WORD)
    else $error("input taken off the sampling boundary");

  a_reset_clear: assert property (disable iff (1'b0)
    rst_i |=> (r_reg.phase == `RHCE_PH_RST && r_reg.u_hist == 3'h0 && r_reg.par_hist == 3'h0
               && !serial_data_o && !bit_clk_o && !sample_clk_o))
    else $error("reset did not clear encoder");

  a_bipolar_copy: assert property (
    bipolar_serial_out_o == serial_data_o)
    else $error("bipolar serial output differs from serial data");

  a_four_level_map: assert property (
    four_level_out_o == {par_word_o.hi, par_word_o.lo})
    else $error("four level code differs from parallel bits");

  a_par_hold_slot: assert property (
    (r_reg.phase != `RHCE_PH_PAR) |-> $stable(par_word_o))
    else $error("parallel bits changed off their edge");

  a_ser_high_first: assert property (
    $rose(sample_clk_o) |-> serial_data_o == r_reg.word.hi)
    else $error("high branch bit not sent first");

  a_word_hold_slot: assert property (
    (r_reg.phase != `RHCE_PH_WORD) |-> $stable(r_reg.word))
    else $error("codeword changed inside its period");

  a_under_normal: assert property (
    (r_reg.phase == `RHCE_PH_WORD && r_reg.mode == rhce_mode_normal) |->
      underrun_o == !$past(fifo_valid))
    else $error("underrun flag does not match empty input");

  a_under_test: assert property (
    (r_reg.phase == `RHCE_PH_WORD && r_reg.mode == rhce_mode_test) |-> !underrun_o)
    else $error("underrun flagged in test mode");

  a_nonsys_high: assert property (
    (r_reg.phase == `RHCE_PH_WORD && r_reg.code == rhce_code_nonsys && seen_reg == 2'h3) |->
      r_reg.word.hi == (r_reg.u_hist[0] ^ $past(r_reg.u_hist[0], 8)
                        ^ $past(r_reg.u_hist[0], 16)))
    else $error("nonsystematic high branch wrong");

  a_sys_memory: assert property (
    (r_reg.phase == `RHCE_PH_WORD && r_reg.code == rhce_code_sys && seen_reg == 2'h3) |->
      r_reg.par_hist == {$past(r_reg.word.lo, 16), $past(r_reg.word.lo, 8), r_reg.word.lo})
    else $error("systematic parity memory wrong");

  a_pop_at_boundary: assert property (
    fifo_pop |-> r_reg.phase == 3'h7)
    else $error("input popped away from the word boundary");

  a_sclk_on_bclk: assert property (
    $rose(sample_clk_o) |-> $rose(bit_clk_o))
    else $error("sampling clock not aligned to bit clock");
endmodule : rhce_encoder

// File: rhce_encoder_test.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s exp=%0h got=%0h", n, e, g); end end
module rhce_encoder_test;
  import rhce_pkg::*;
  logic       sys_clk_i = 1'h0, rst_i = 1'h1, en = 1'h1, bit_r = 1'h0;
  logic       dat, vld, rdy, ser, bip, bclk, sclk, und, u, lo, e_und, have;
  rhce_code_e code = rhce_code_nonsys;
  rhce_mode_e mode = rhce_mode_normal;
  rhce_word_s par;
  logic [1:0] lvl;
  logic [7:0] lf = 8'h2e;
  logic [2:0] ph = 3'h7, uh = 3'h0, yh = 3'h0, cur;
  int         n_mismatch = 0, cmp_count = 0;
  logic       bq[$];
  logic [2:0] eq[$];

  always #2.5 sys_clk_i = ~sys_clk_i;

  rhce_encoder u_rhce_encoder (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .code_sel_i(code),
    .mode_sel_i(mode), .data_i(dat), .data_valid_i(vld), .data_ready_o(rdy),
    .serial_data_o(ser), .bipolar_serial_out_o(bip), .bit_clk_o(bclk), .par_word_o(par),
    .four_level_out_o(lvl), .sample_clk_o(sclk), .underrun_o(und));
  rhce_src u_rhce_src (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .en_i(en), .bit_i(bit_r),
    .sample_clk_i(sclk), .ready_i(rdy), .data_o(dat), .valid_o(vld));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  // Reference: note expected word {hi, lo, underrun} per codeword
  always @(posedge sys_clk_i) begin
    ph <= rst_i ? 3'h7 : ph + 3'h1;
    lf <= lfsr(lf);
    bit_r <= lf[0];
    if (rst_i) begin
      bq.delete();
      eq.delete();
      uh <= 3'h0;
      yh <= 3'h0;
    end else begin
      if (ph == 3'h7) begin
        u = 1'h1;
        e_und = 1'h0;
        if (mode == rhce_mode_normal) begin
          e_und = (bq.size() == 0);
          u = e_und ? 1'h0 : bq.pop_front();
        end
        lo = (code == rhce_code_sys) ? yh[0] ^ yh[2] ^ uh[1] : u ^ uh[1];
        eq.push_back({(code == rhce_code_sys) ? u : u ^ uh[0] ^ uh[1], lo, e_und});
        uh <= {uh[1:0], u};
        yh <= {yh[1:0], lo};
      end
      if (vld && rdy) bq.push_back(dat);
    end
  end

  // Monitor: compare outputs with oldest note
  // decoder-side hard sampling
  always @(posedge sys_clk_i) begin
    if (rst_i) have = 1'h0;
    else begin
      if (ph == 3'h0 && eq.size() > 0) begin
        cur = eq.pop_front();
        have = 1'h1;
      end
      if (have && ph == 3'h0) `CHK("hi", {2'h3, cur[2], cur[2], cur[0]}, {bclk, sclk, ser, bip, und})
      if (have && ph == 3'h2) `CHK("par", {cur[2:1], cur[2:1], 1'h0}, {par, lvl, bclk})
      if (have && ph == 3'h4) `CHK("lo", {2'h2, cur[1], cur[1]}, {bclk, sclk, ser, bip})
    end
  end

  task print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict

  task run(input rhce_code_e c, input rhce_mode_e m, input logic e, input int w,
           input logic flip, input string nm);
    @(posedge sys_clk_i);
    code <= c;
    mode <= m;
    en <= e;
    repeat (w * 8) begin
      @(posedge sys_clk_i);
      if (flip && lf[4:2] == 3'h5) code <= rhce_code_e'(lf[1]);
    end
    $display("%s done", nm);
  endtask : run

  initial begin
    repeat (6) @(posedge sys_clk_i);
    rst_i <= 1'h0;
    run(rhce_code_nonsys, rhce_mode_normal, 1'h1, 30, 1'h0, "nonsys");
    run(rhce_code_sys, rhce_mode_normal, 1'h1, 30, 1'h0, "sys");
    run(rhce_code_nonsys, rhce_mode_test, 1'h1, 24, 1'h0, "test_nonsys");
    `CHK("full", 1'h0, rdy)
    run(rhce_code_sys, rhce_mode_test, 1'h1, 8, 1'h0, "test_sys");
    run(rhce_code_sys, rhce_mode_normal, 1'h0, 24, 1'h0, "drain");
    run(rhce_code_nonsys, rhce_mode_normal, 1'h1, 40, 1'h1, "flip");
    rst_i <= 1'h1;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'h0;
    run(rhce_code_sys, rhce_mode_normal, 1'h1, 20, 1'h1, "rerst");
    print_verdict;
  end

  initial begin
    #15000;
    n_mismatch++;
    print_verdict;
  end
endmodule : rhce_encoder_test

// File: rhce_pkg.sv
`include "rhce_consts.svh"
package rhce_pkg;
  typedef enum logic {rhce_code_nonsys, rhce_code_sys} rhce_code_e;
  typedef enum logic {rhce_mode_normal, rhce_mode_test} rhce_mode_e;
  typedef struct packed {
    logic hi;
    logic lo;
  } rhce_word_s;
  typedef struct packed {
    logic [`RHCE_PH_W-1:0] phase;
    rhce_code_e            code;
    rhce_mode_e            mode;
    logic [2:0]            u_hist;
    logic [2:0]            par_hist;
    rhce_word_s            word;
    rhce_word_s            par;
    logic                  ser;
    logic                  bclk;
    logic                  sclk;
    logic                  underrun;
  } rhce_state_s;
endpackage : rhce_pkg

// File: rhce_src.sv
`timescale 1ns/1ps
module rhce_src (
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  // Source control
  input  wire logic en_i,
  input  wire logic bit_i,
  input  wire logic sample_clk_i,
  // Stream to encoder
  input  wire logic ready_i,
  output logic      data_o,
  output logic      valid_o
);
  logic sclk_reg;
  always_ff @(posedge sys_clk_i) begin
    sclk_reg <= sample_clk_i;
    if (rst_i) begin
      valid_o <= 1'h0;
      data_o  <= 1'h0;
    end else if (en_i && sample_clk_i && !sclk_reg && !(valid_o && !ready_i)) begin
      valid_o <= 1'h1;
      data_o  <= bit_i;
    end else if (!valid_o || ready_i) begin
      // Released line shows no stale bit
      valid_o <= 1'h0;
      data_o  <= ~data_o;
    end
  end
endmodule : rhce_src
